// >>> rtl/adccc_params.svh
`ifndef ADCCC_PARAMS_SVH
`define ADCCC_PARAMS_SVH

`define ADCCC_COEFF_W    24
`define ADCCC_DATA_W     30
`define ADCCC_CODE_W     18
`define ADCCC_GAIN_FRAC  23
`define ADCCC_OUT_SHIFT  6
`define ADCCC_SEL_SYS_OFF  2'h0
`define ADCCC_SEL_SYS_GAIN 2'h1
`define ADCCC_SEL_SELF_OFF 2'h2
`define ADCCC_COEFF_RST  24'h000000
`define ADCCC_CODE_RST   18'h00000
`define ADCCC_TC_MAX     18'h1ffff
`define ADCCC_TC_MIN     18'h20000
`define ADCCC_OB_MAX     18'h3ffff
`define ADCCC_OB_MIN     18'h00000
`define ADCCC_OB_FLIP    18'h20000
`define ADCCC_BIP_HI     30'sh0001ffff
`define ADCCC_BIP_LO     30'sh3ffe0000
`define ADCCC_UNI_HI     30'sh0003ffff
`define ADCCC_CNT_RST    5'h00
`define ADCCC_CNT_LAST   5'h17
`define ADCCC_CNT_ONE    5'h01

`endif

// >>> rtl/adccc_pkg.sv
package adccc_pkg;
  typedef enum logic {st_idle, st_shift} adccc_state_t;
  typedef logic signed [23:0] adccc_coeff_t;
  typedef logic signed [29:0] adccc_data_t;
endpackage

// >>> rtl/adccc_gain.sv
`timescale 1ns/1ns
`default_nettype none
`include "adccc_params.svh"
module adccc_gain (
  input  wire logic                 enable, // apply scaling
  input  wire adccc_pkg::adccc_data_t  din,    // value in
  input  wire adccc_pkg::adccc_coeff_t coeff,  // signed gain coefficient
  output var adccc_pkg::adccc_data_t  dout    // scaled value
);
  logic signed [53:0] prod;
  logic signed [53:0] prod_s;

  always_comb
  begin
    prod   = din * coeff;
    prod_s = prod >>> `ADCCC_GAIN_FRAC;
    dout   = enable ? (din + prod_s[29:0]) : din;
  end
endmodule
`default_nettype wire

// >>> rtl/adccc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "adccc_params.svh"
module adccc_top (
  input  wire logic                    clock,                 // 100 MHz
  input  wire logic                    rst,                   // sync, active high
  input  wire logic                    raw_valid,             // raw result strobe
  input  wire adccc_pkg::adccc_coeff_t raw_data,              // signed raw result
  input  wire logic                    bipolar,               // 1 bipolar, 0 unipolar
  input  wire logic                    format,                // bipolar coding select
  input  wire logic                    system_offset_disable, // skip system offset
  input  wire logic                    system_gain_disable,   // skip system gain
  input  wire logic                    self_offset_disable,   // skip self offset
  input  wire logic                    self_gain_disable,     // skip self gain
  input  wire adccc_pkg::adccc_coeff_t self_gain_coeff,       // self gain value
  input  wire logic                    acc_start,             // begin register access
  input  wire logic                    acc_write,             // 1 write, 0 read
  input  wire logic [1:0]              acc_sel,               // coefficient select
  input  wire logic                    bit_strobe,            // one serial bit
  input  wire logic                    sdi,                   // serial data in
  input  wire logic                    cal_busy,              // calibration running
  input  wire logic                    cal_load,              // calibration result strobe
  input  wire logic [1:0]              cal_sel,               // calibrated coefficient
  input  wire adccc_pkg::adccc_coeff_t cal_value,             // measured value
  output logic                         sdo,                   // serial data out
  output logic                         acc_done,              // access finished pulse
  output logic                         result_valid,          // result strobe
  output logic [17:0]                  result                 // coded result
);

  ////////////////////////////////////////////////////////////////////////
  // coefficient registers and serial access

  adccc_pkg::adccc_state_t state_r, state_nxt;
  adccc_pkg::adccc_coeff_t sys_off_r, sys_off_nxt;
  adccc_pkg::adccc_coeff_t sys_gain_r, sys_gain_nxt;
  adccc_pkg::adccc_coeff_t self_off_r, self_off_nxt;
  adccc_pkg::adccc_coeff_t shift_r, shift_nxt;
  logic [4:0]              cnt_r, cnt_nxt;
  logic [1:0]              sel_r, sel_nxt;
  logic                    wr_r, wr_nxt;
  logic                    sdo_r, sdo_nxt;
  logic                    done_r, done_nxt;
  logic                    commit;

  function automatic adccc_pkg::adccc_coeff_t pick(input logic [1:0] s,
                                                   input adccc_pkg::adccc_coeff_t a,
                                                   input adccc_pkg::adccc_coeff_t b,
                                                   input adccc_pkg::adccc_coeff_t c);
    case (s)
      `ADCCC_SEL_SYS_OFF:  pick = a;
      `ADCCC_SEL_SYS_GAIN: pick = b;
      `ADCCC_SEL_SELF_OFF: pick = c;
      default:             pick = `ADCCC_COEFF_RST;
    endcase
  endfunction

  always_comb
  begin
    state_nxt    = state_r;
    shift_nxt    = shift_r;
    cnt_nxt      = cnt_r;
    sel_nxt      = sel_r;
    wr_nxt       = wr_r;
    done_nxt     = 1'b0;
    commit       = 1'b0;
    sys_off_nxt  = sys_off_r;
    sys_gain_nxt = sys_gain_r;
    self_off_nxt = self_off_r;
    case (state_r)
      adccc_pkg::st_idle:
        if (acc_start)
        begin
          state_nxt = adccc_pkg::st_shift;
          sel_nxt   = acc_sel;
          wr_nxt    = acc_write;
          cnt_nxt   = `ADCCC_CNT_RST;
          shift_nxt = pick(acc_sel, sys_off_r, sys_gain_r, self_off_r);
        end
      adccc_pkg::st_shift:
        if (bit_strobe)
        begin
          shift_nxt = {shift_r[22:0], sdi};
          cnt_nxt   = cnt_r + `ADCCC_CNT_ONE;
          if (cnt_r == `ADCCC_CNT_LAST)
          begin
            state_nxt = adccc_pkg::st_idle;
            done_nxt  = 1'b1;
            commit    = wr_r && !cal_busy;
          end
        end
      default:
        state_nxt = adccc_pkg::st_idle;
    endcase
    if (commit)
    begin
      case (sel_r)
        `ADCCC_SEL_SYS_OFF:  sys_off_nxt  = shift_nxt;
        `ADCCC_SEL_SYS_GAIN: sys_gain_nxt = shift_nxt;
        `ADCCC_SEL_SELF_OFF: self_off_nxt = shift_nxt;
        default:             sys_off_nxt  = sys_off_r;
      endcase
    end
    if (cal_load)
    begin
      case (cal_sel)
        `ADCCC_SEL_SYS_OFF:  sys_off_nxt  = cal_value;
        `ADCCC_SEL_SYS_GAIN: sys_gain_nxt = cal_value;
        `ADCCC_SEL_SELF_OFF: self_off_nxt = cal_value;
        default:             sys_off_nxt  = sys_off_nxt;
      endcase
    end
    sdo_nxt = shift_nxt[23];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_r    <= adccc_pkg::st_idle;
      shift_r    <= `ADCCC_COEFF_RST;
      cnt_r      <= `ADCCC_CNT_RST;
      sel_r      <= `ADCCC_SEL_SYS_OFF;
      wr_r       <= 1'b0;
      sdo_r      <= 1'b0;
      done_r     <= 1'b0;
      sys_off_r  <= `ADCCC_COEFF_RST;
      sys_gain_r <= `ADCCC_COEFF_RST;
      self_off_r <= `ADCCC_COEFF_RST;
    end
    else
    begin
      state_r    <= state_nxt;
      shift_r    <= shift_nxt;
      cnt_r      <= cnt_nxt;
      sel_r      <= sel_nxt;
      wr_r       <= wr_nxt;
      sdo_r      <= sdo_nxt;
      done_r     <= done_nxt;
      sys_off_r  <= sys_off_nxt;
      sys_gain_r <= sys_gain_nxt;
      self_off_r <= self_off_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // correction datapath

  adccc_pkg::adccc_data_t x_raw, x_so, x_sg, x_yo, x_yg, x_sc;
  logic [17:0]            code_nxt, result_r;
  logic                   rv_nxt, rv_r;

  function automatic logic [17:0] clamp_code(input adccc_pkg::adccc_data_t v,
                                             input logic bip,
                                             input logic ob);
    logic [17:0] tc;
    tc = v[17:0];
    if (bip)
    begin
      if (v > `ADCCC_BIP_HI)
        tc = `ADCCC_TC_MAX;
      else if (v < $signed(`ADCCC_BIP_LO))
        tc = `ADCCC_TC_MIN;
      clamp_code = ob ? (tc ^ `ADCCC_OB_FLIP) : tc;
    end
    else if (v < 0)
      clamp_code = `ADCCC_OB_MIN;
    else if (v > `ADCCC_UNI_HI)
      clamp_code = `ADCCC_OB_MAX;
    else
      clamp_code = tc;
  endfunction

  always_comb
  begin
    x_raw = adccc_pkg::adccc_data_t'(raw_data);
    x_so  = self_offset_disable ? x_raw : (x_raw - adccc_pkg::adccc_data_t'(self_off_r));
  end

  adccc_gain u_self_gain (
    .enable (!self_gain_disable),
    .din    (x_so),
    .coeff  (self_gain_coeff),
    .dout   (x_sg)
  );

  always_comb
  begin
    x_yo = system_offset_disable ? x_sg : (x_sg - adccc_pkg::adccc_data_t'(sys_off_r));
  end

  adccc_gain u_sys_gain (
    .enable (!system_gain_disable),
    .din    (x_yo),
    .coeff  (sys_gain_r),
    .dout   (x_yg)
  );

  // unipolar doubling after offsets and gains; clamp and code
  always_comb
  begin
    x_sc     = bipolar ? x_yg : (x_yg <<< 1);
    code_nxt = clamp_code(x_sc >>> `ADCCC_OUT_SHIFT, bipolar, format);
    rv_nxt   = raw_valid;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      result_r <= `ADCCC_CODE_RST;
      rv_r     <= 1'b0;
    end
    else
    begin
      result_r <= raw_valid ? code_nxt : result_r;
      rv_r     <= rv_nxt;
    end
  end

  assign sdo          = sdo_r;
  assign acc_done     = done_r;
  assign result_valid = rv_r;
  assign result       = result_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic all_off;
  assign all_off = system_offset_disable && system_gain_disable &&
                   self_offset_disable && self_gain_disable;

  adccc_pkg::adccc_coeff_t acc_pick;
  logic                    pick_msb;
  assign acc_pick = pick(acc_sel, sys_off_r, sys_gain_r, self_off_r);
  assign pick_msb = acc_pick[23];

  property p_tc_zero;
    @(posedge clock) disable iff (rst)
    raw_valid && bipolar && !format && all_off && raw_data == 24'sh000000
      |=> result == `ADCCC_CODE_RST;
  endproperty
  a_tc_zero: assert property (p_tc_zero) else $error("tc zero code wrong");

  property p_ob_top;
    @(posedge clock) disable iff (rst)
    raw_valid && bipolar && format && all_off && raw_data == 24'sh7fffff
      |=> result == `ADCCC_OB_MAX;
  endproperty
  a_ob_top: assert property (p_ob_top) else $error("offset binary top wrong");

  property p_uni_half;
    @(posedge clock) disable iff (rst)
    raw_valid && !bipolar && all_off && raw_data == 24'sh400000
      |=> result == `ADCCC_OB_FLIP;
  endproperty
  a_uni_half: assert property (p_uni_half) else $error("unipolar half wrong");

  property p_uni_clamp;
    @(posedge clock) disable iff (rst)
    raw_valid && !bipolar && all_off && raw_data[23]
      |=> result == `ADCCC_OB_MIN;
  endproperty
  a_uni_clamp: assert property (p_uni_clamp) else $error("unipolar clamp wrong");

  property p_sys_off;
    @(posedge clock) disable iff (rst)
    raw_valid && bipolar && !format && self_offset_disable && self_gain_disable &&
    system_gain_disable && !system_offset_disable && raw_data == sys_off_r
      |=> result == `ADCCC_CODE_RST;
  endproperty
  a_sys_off: assert property (p_sys_off) else $error("system offset not removed");

  property p_self_off;
    @(posedge clock) disable iff (rst)
    raw_valid && bipolar && !format && system_offset_disable && self_gain_disable &&
    system_gain_disable && !self_offset_disable && raw_data == self_off_r
      |=> result == `ADCCC_CODE_RST;
  endproperty
  a_self_off: assert property (p_self_off) else $error("self offset not removed");

  property p_gain_half;
    @(posedge clock) disable iff (rst)
    raw_valid && bipolar && !format && system_offset_disable && self_gain_disable &&
    self_offset_disable && !system_gain_disable && sys_gain_r == 24'shc00000 &&
    raw_data == 24'sh400000
      |=> result == 18'h08000;
  endproperty
  a_gain_half: assert property (p_gain_half) else $error("half gain wrong");

  property p_gain_two;
    @(posedge clock) disable iff (rst)
    raw_valid && bipolar && !format && system_offset_disable && self_gain_disable &&
    self_offset_disable && !system_gain_disable && sys_gain_r == 24'sh7fffff &&
    raw_data == 24'sh200000
      |=> result >= 18'h0fffe && result <= 18'h10000;
  endproperty
  a_gain_two: assert property (p_gain_two) else $error("double gain off");

  property p_read_msb;
    @(posedge clock) disable iff (rst)
    state_r == adccc_pkg::st_idle && acc_start && !acc_write
      |=> sdo == $past(pick_msb);
  endproperty
  a_read_msb: assert property (p_read_msb) else $error("read not msb first");

  property p_cal_sys;
    @(posedge clock) disable iff (rst)
    cal_load && cal_sel == `ADCCC_SEL_SYS_GAIN |=> sys_gain_r == $past(cal_value);
  endproperty
  a_cal_sys: assert property (p_cal_sys) else $error("calibration not stored");

  property p_cal_self;
    @(posedge clock) disable iff (rst)
    cal_load && cal_sel == `ADCCC_SEL_SELF_OFF |=> self_off_r == $past(cal_value);
  endproperty
  a_cal_self: assert property (p_cal_self) else $error("self calibration lost");

  property p_hold;
    @(posedge clock) disable iff (rst)
    !cal_load && !commit |=> $stable(sys_off_r);
  endproperty
  a_hold: assert property (p_hold) else $error("system offset changed");

  c_write: cover property (@(posedge clock) disable iff (rst) commit);
  c_read:  cover property (@(posedge clock) disable iff (rst) done_r && !wr_r);
  c_sat:   cover property (@(posedge clock) disable iff (rst)
                           result_valid && result == `ADCCC_TC_MAX && !format);
endmodule
`default_nettype wire

// >>> verif/adccc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module adccc_host_model (
  input  wire logic  clock,      // block clock
  input  wire logic  sdo,        // read bit
  input  wire logic  acc_done,   // access finished
  output logic       acc_start,  // access request
  output logic       acc_write,  // 1 write, 0 read
  output logic [1:0] acc_sel,    // coefficient select
  output logic       bit_strobe, // one bit per pulse
  output logic       sdi         // write bit
);
  initial
  begin
    acc_start  = 1'b0;
    acc_write  = 1'b0;
    acc_sel    = 2'h0;
    bit_strobe = 1'b0;
    sdi        = 1'b0;
  end

  // one access, gap idle cycles after each bit; called at a falling edge
  task automatic access(input logic wr, input logic [1:0] sel,
                        input adccc_pkg::adccc_coeff_t wd, input int gap,
                        output adccc_pkg::adccc_coeff_t rd, output logic ok);
    int k;
    rd = 24'h000000;
    ok = 1'b0;
    acc_start = 1'b1;
    acc_write = wr;
    acc_sel   = sel;
    @(negedge clock);
    acc_start = 1'b0;
    acc_write = ~wr;
    acc_sel   = ~sel;
    for (k = 23; k >= 0; k--)
    begin
      rd[k] = sdo;
      bit_strobe = 1'b1;
      sdi = wd[k];
      @(negedge clock);
      if (k == 0)
        ok = (acc_done === 1'b1);
      if (gap > 0)
      begin
        bit_strobe = 1'b0;
        sdi = ~wd[k];
        repeat (gap) @(negedge clock);
      end
    end
    bit_strobe = 1'b0;
    sdi = ~sdi;
  endtask
endmodule
`default_nettype wire

// >>> verif/adc_calibration_correction_bench.sv
`timescale 1ns/1ns
`default_nettype none
module adc_calibration_correction_bench;
  logic                    clock     = 1'b0;
  logic                    rst       = 1'b1;
  logic                    raw_valid = 1'b0;
  adccc_pkg::adccc_coeff_t raw_data  = 24'h000000;
  logic                    bipolar   = 1'b1;
  logic                    format    = 1'b0;
  logic [3:0]              dis       = 4'hf; // sys off, sys gain, self off, self gain
  adccc_pkg::adccc_coeff_t sg_coeff  = 24'h000000;
  logic                    cal_busy  = 1'b0;
  logic                    cal_load  = 1'b0;
  logic [1:0]              cal_sel   = 2'h0;
  adccc_pkg::adccc_coeff_t cal_value = 24'h000000;
  logic                    acc_start, acc_write, bit_strobe, sdi, sdo, acc_done;
  logic                    result_valid;
  logic [1:0]              acc_sel;
  logic [17:0]             result;
  adccc_pkg::adccc_coeff_t shadow [3] = '{default: 24'h000000};
  adccc_pkg::adccc_coeff_t codes [5] = '{24'h7fffff, 24'h000000, 24'h400000,
                                         24'h000040, 24'h800000};
  logic [17:0]             exp_q [$];
  int                      tol_q [$];
  int                      n_fail    = 0;
  int                      compares  = 0;
  logic [31:0]             rnd       = 32'hc41fb615;

  always #5 clock = ~clock;

  adccc_top u_dut (
    .clock(clock), .rst(rst), .raw_valid(raw_valid), .raw_data(raw_data),
    .bipolar(bipolar), .format(format), .system_offset_disable(dis[3]),
    .system_gain_disable(dis[2]), .self_offset_disable(dis[1]),
    .self_gain_disable(dis[0]), .self_gain_coeff(sg_coeff),
    .acc_start(acc_start), .acc_write(acc_write), .acc_sel(acc_sel),
    .bit_strobe(bit_strobe), .sdi(sdi), .cal_busy(cal_busy), .cal_load(cal_load),
    .cal_sel(cal_sel), .cal_value(cal_value), .sdo(sdo), .acc_done(acc_done),
    .result_valid(result_valid), .result(result)
  );

  adccc_host_model u_host (
    .clock(clock), .sdo(sdo), .acc_done(acc_done), .acc_start(acc_start),
    .acc_write(acc_write), .acc_sel(acc_sel), .bit_strobe(bit_strobe), .sdi(sdi)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction

  // expected code: self offset, self gain, system offset, system gain (gains 1 + c/2^23), doubling, shift, clamp, coding
  function automatic logic [17:0] model(input adccc_pkg::adccc_coeff_t raw);
    longint x;
    longint lo;
    longint hi;
    x = raw;
    if (!dis[1]) x = x - shadow[2];
    if (!dis[0]) x = (x * (longint'(sg_coeff) + 64'sh800000)) >>> 23;
    if (!dis[3]) x = x - shadow[0];
    if (!dis[2]) x = (x * (longint'(shadow[1]) + 64'sh800000)) >>> 23;
    if (!bipolar) x = x * 2;
    x = x >>> 6;
    lo = bipolar ? -64'sh20000 : 64'sh0;
    hi = bipolar ? 64'sh1ffff : 64'sh3ffff;
    if (x < lo) x = lo;
    if (x > hi) x = hi;
    model = x[17:0] ^ ((bipolar && format) ? 18'h20000 : 18'h00000);
  endfunction

  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp, input int tol);
    logic [17:0] d;
    logic        ok;
    d = seen[17:0] - exp[17:0];
    ok = (tol == 0) ? (seen === exp) : (d <= tol || d > 18'h3ffff - tol);
    compares++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic acc(input logic wr, input logic [1:0] sel,
                     input adccc_pkg::adccc_coeff_t wd, input int gap, input logic keep);
    adccc_pkg::adccc_coeff_t rd;
    logic                    ok;
    u_host.access(wr, sel, wd, gap, rd, ok);
    check("access done", {23'h0, ok}, 24'h000001, 0);
    if (wr && keep && sel != 2'h3) shadow[sel] = wd;
    if (!wr) check("coefficient", rd, (sel == 2'h3) ? 24'h000000 : shadow[sel], 0);
  endtask

  task automatic conv(input adccc_pkg::adccc_coeff_t raw);
    raw_data  = raw;
    raw_valid = 1'b1;
    exp_q.push_back(model(raw));
    tol_q.push_back((dis[0] && dis[2]) ? 0 : 2);
    @(negedge clock);
  endtask

  task automatic done_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(negedge clock)
  begin
    if (result_valid === 1'b1 && exp_q.size() > 0)
      check("result", {6'h00, result}, {6'h00, exp_q.pop_front()}, tol_q.pop_front());
    else if (result_valid !== 1'b0)
      check("spare result", 24'h000001, 24'h000000, 0);
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    n_fail++;
    conclude();
  end

  initial
  begin
    int i;
    repeat (5) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    check("result after reset", {6'h00, result}, 24'h000000, 0);
    for (i = 0; i < 4; i++)
      acc(1'b0, i[1:0], 24'h000000, 0, 1'b1);
    done_test("reset values");
    for (i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      acc(1'b1, i[1:0], rnd[23:0], i, 1'b1);
      acc(1'b0, i[1:0], 24'h000000, 3 - i, 1'b1);
    end
    done_test("write and read back");
    cal_busy = 1'b1;
    acc(1'b1, 2'h0, 24'h5a5a5a, 0, 1'b0);
    cal_busy = 1'b0;
    acc(1'b0, 2'h0, 24'h000000, 0, 1'b1);
    cal_load = 1'b1;
    for (i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      cal_sel = i[1:0];
      cal_value = rnd[23:0];
      shadow[i] = rnd[23:0];
      @(negedge clock);
    end
    cal_load = 1'b0;
    for (i = 0; i < 3; i++)
      acc(1'b0, i[1:0], 24'h000000, 1, 1'b1);
    done_test("calibration load");
    for (i = 0; i < 15; i++)
    begin
      bipolar = (i < 10);
      format = (i >= 5);
      conv(codes[i % 5]);
    end
    raw_valid = 1'b0;
    for (i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      acc(1'b1, i[1:0], {{4{rnd[19]}}, rnd[19:0]}, 0, 1'b1);
    end
    done_test("coding table");
    for (i = 0; i < 80; i++)
    begin
      rnd = lfsr(rnd);
      dis = rnd[3:0];
      bipolar = rnd[4];
      format = rnd[5];
      sg_coeff = rnd[31:8];
      rnd = lfsr(rnd);
      conv(bipolar ? rnd[23:0] : {1'b0, rnd[22:0]});
    end
    sg_coeff = 24'h000000;
    bipolar = 1'b1;
    format = 1'b0;
    dis = 4'h7;
    conv(shadow[0]);
    dis = 4'hd;
    conv(shadow[2]);
    raw_valid = 1'b0;
    acc(1'b1, 2'h1, 24'hc00000, 0, 1'b1);
    dis = 4'hb;
    conv(24'h400000);
    raw_valid = 1'b0;
    acc(1'b1, 2'h1, 24'h7fffff, 0, 1'b1);
    conv(24'h200000);
    raw_valid = 1'b0;
    repeat (3) @(negedge clock);
    check("pending results", 24'(exp_q.size()), 24'h000000, 0);
    for (i = 0; i < 3; i++)
      acc(1'b0, i[1:0], 24'h000000, 0, 1'b1);
    done_test("random corrections");
    conclude();
  end
endmodule
`default_nettype wire
